// *** tcrb_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module tcrb_asserts
	import tcrb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic shutdown_n,
	input wire logic scl_i,
	input wire logic sda_oe,
	input wire logic fb_div_clk,
	input wire logic ref_div_clk,
	input wire logic lo_clk,
	input wire logic detector_rms,
	input wire logic [7:0] loop_config,
	input wire logic [7:0] operating_control,
	input wire logic [7:0] feedback_divider_low,
	input wire logic [2:0] trim_code,
	input wire logic [7:0] trim_scale_pct,
	input wire logic [9:0] centre_khz,
	input wire logic pump_force_source,
	input wire logic pump_force_sink,
	input wire logic pump_force_hiz,
	input wire logic detector_out,
	input wire logic test_pin_out
);
	localparam logic [7:0] PCT [8] = '{8'h4b, 8'h50, 8'h56, 8'h5c, 8'h64, 8'h6c, 8'h77, 8'h84};
	localparam logic [9:0] KHZ [8] = '{10'h1ac, 10'h1c9, 10'h1eb, 10'h20d, 10'h23b, 10'h269,
		10'h2a7, 10'h2f2};
	wire logic rs;
	assign rs = rst_n & shutdown_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!rs);
	sequence s_exit;
		$rose(rs);
	endsequence
	sequence s_rst_vals;
		loop_config == RST_LOOP_CONFIG && operating_control == RST_OTHER && !sda_oe;
	endsequence
	a_reset_values: assert property (s_exit |-> s_rst_vals)
		else $error("config not at reset values");
	a_fb_low_bits: assert property (feedback_divider_low[2:0] == 3'h0)
		else $error("ignored divider bits stored");
	a_pump_onehot: assert property (
		$onehot0({pump_force_source, pump_force_sink, pump_force_hiz}))
		else $error("more than one pump force active");
	a_pump_vs_route: assert property (
		(pump_force_source | pump_force_sink | pump_force_hiz) |-> !detector_out && !test_pin_out)
		else $error("pump force and routing together");
	a_det_route: assert property (detector_out |-> detector_rms)
		else $error("detector output without source");
	a_test_pin_src: assert property (test_pin_out |-> fb_div_clk | ref_div_clk | lo_clk)
		else $error("test pin high without source");
	a_trim_scale: assert property (trim_scale_pct == PCT[trim_code])
		else $error("trim scale wrong for code");
	a_centre_khz: assert property (centre_khz == KHZ[trim_code])
		else $error("centre frequency wrong for code");
	// answer bits may only move while the clock line is low
	a_ack_on_low: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data line moved with clock high");
endmodule : tcrb_asserts
bind tcrb_top tcrb_asserts u_tcrb_asserts (.clk, .rst_n, .shutdown_n, .scl_i, .sda_oe,
	.fb_div_clk, .ref_div_clk, .lo_clk, .detector_rms, .loop_config, .operating_control,
	.feedback_divider_low,
	.trim_code, .trim_scale_pct, .centre_khz, .pump_force_source, .pump_force_sink, .pump_force_hiz,
	.detector_out, .test_pin_out);
`default_nettype wire

// *** tcrb_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module tcrb_host (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_oe
);
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	// 4- and 8-clock phases keep each level well past the 2-flop sync
	task automatic ph(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : ph
	task automatic start();
		ph(4);
		sda_oe = 1'b0;
		ph(4);
		scl = 1'b1;
		ph(8);
		sda_oe = 1'b1;
		ph(8);
		scl = 1'b0;
	endtask : start
	task automatic xbit(input logic b, output logic r);
		ph(4);
		sda_oe = ~b;
		ph(4);
		scl = 1'b1;
		ph(8);
		r = sda;
		scl = 1'b0;
	endtask : xbit
	task automatic xbyte(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) begin
			xbit(w[i], r[i]);
		end
		xbit(a, k);
	endtask : xbyte
	task automatic stop();
		ph(4);
		sda_oe = 1'b1;
		ph(4);
		scl = 1'b1;
		ph(8);
		sda_oe = 1'b0;
		ph(8);
	endtask : stop
endmodule : tcrb_host
`default_nettype wire

// *** tcrb_pkg.sv ***
package tcrb_pkg;
	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam int NUM_CFG = 8;
	localparam logic [7:0] ADDR_TEST_DIAG = 8'h00;
	localparam logic [7:0] ADDR_LOOP_CONFIG = 8'h01;
	localparam logic [7:0] ADDR_OSC_CONFIG = 8'h02;
	localparam logic [7:0] ADDR_OPER_CONTROL = 8'h03;
	localparam logic [7:0] ADDR_REF_DIV_POWER = 8'h04;
	localparam logic [7:0] ADDR_REF_DIVIDER = 8'h05;
	localparam logic [7:0] ADDR_FB_DIV_HIGH = 8'h06;
	localparam logic [7:0] ADDR_FB_DIV_LOW = 8'h07;

	// ----------------------------------------
	// test register fields and divider low-byte mask
	// ----------------------------------------
	localparam int TRIM_MSB = 7;
	localparam int TRIM_LSB = 5;
	localparam int TRIM_SRC_BIT = 4;
	localparam int MIX_DIS_BIT = 3;
	localparam int DIAG_MSB = 2;
	localparam int DIAG_LSB = 0;
	localparam logic [7:0] FB_LOW_KEEP_MASK = 8'hf8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_TEST_DIAG = 8'h10;
	localparam logic [7:0] RST_LOOP_CONFIG = 8'hf1;
	localparam logic [7:0] RST_OSC_CONFIG = 8'hd8;
	localparam logic [7:0] RST_OTHER = 8'h00;

	// ----------------------------------------
	// filter centre
	// ----------------------------------------
	localparam int NOMINAL_KHZ = 571;
	localparam logic [2:0] TRIM_NOMINAL = 3'h4;

	typedef enum logic [2:0] {
		TCRB_DIAG_NORMAL = 3'b000,
		TCRB_DIAG_PUMP_SOURCE = 3'b001,
		TCRB_DIAG_PUMP_SINK = 3'b010,
		TCRB_DIAG_PUMP_HIZ = 3'b011,
		TCRB_DIAG_DET_RMS = 3'b100,
		TCRB_DIAG_FB_DIV = 3'b101,
		TCRB_DIAG_REF_DIV = 3'b110,
		TCRB_DIAG_LO = 3'b111
	} tcrb_diag_t;

	typedef enum logic [2:0] {
		TCRB_IDLE = 3'b000,
		TCRB_ADDR = 3'b001,
		TCRB_REG = 3'b010,
		TCRB_WDATA = 3'b011,
		TCRB_ACK = 3'b100,
		TCRB_RDATA = 3'b101,
		TCRB_RACK = 3'b110,
		TCRB_RNEXT = 3'b111
	} tcrb_state_t;
endpackage : tcrb_pkg

// *** tcrb_test_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module tcrb_test_decode
	import tcrb_pkg::*;
(
	input wire logic [7:0] test_reg,
	input wire logic [2:0] factory_trim,
	input wire logic fb_div_clk,
	input wire logic ref_div_clk,
	input wire logic lo_clk,
	input wire logic detector_rms,
	output logic [2:0] trim_code,
	output logic [7:0] trim_scale_pct,
	output logic [9:0] centre_khz,
	output logic mixer_disable,
	output logic pump_force_source,
	output logic pump_force_sink,
	output logic pump_force_hiz,
	output logic detector_out,
	output logic test_pin_out
);
	tcrb_diag_t diag;
	logic [2:0] filter_trim;
	logic trim_source_sel;

	assign filter_trim = test_reg[TRIM_MSB:TRIM_LSB];
	assign trim_source_sel = test_reg[TRIM_SRC_BIT];
	assign diag = tcrb_diag_t'(test_reg[DIAG_MSB:DIAG_LSB]);

	// manual field only matters with the source bit cleared
	assign trim_code = trim_source_sel ? factory_trim : filter_trim;
	assign mixer_disable = test_reg[MIX_DIS_BIT];

	always_comb begin
		case (trim_code)
			3'b000: trim_scale_pct = 8'h4b;
			3'b001: trim_scale_pct = 8'h50;
			3'b010: trim_scale_pct = 8'h56;
			3'b011: trim_scale_pct = 8'h5c;
			3'b100: trim_scale_pct = 8'h64;
			3'b101: trim_scale_pct = 8'h6c;
			3'b110: trim_scale_pct = 8'h77;
			3'b111: trim_scale_pct = 8'h84;
			default: trim_scale_pct = 8'h64;
		endcase
	end

	// rounded to the nearest kHz around the nominal centre
	assign centre_khz = 10'((NOMINAL_KHZ * int'(trim_scale_pct) + 50) / 100);

	always_comb begin
		pump_force_source = 1'b0;
		pump_force_sink = 1'b0;
		pump_force_hiz = 1'b0;
		detector_out = 1'b0;
		test_pin_out = 1'b0;
		case (diag)
			TCRB_DIAG_NORMAL: test_pin_out = 1'b0;
			TCRB_DIAG_PUMP_SOURCE: pump_force_source = 1'b1;
			TCRB_DIAG_PUMP_SINK: pump_force_sink = 1'b1;
			TCRB_DIAG_PUMP_HIZ: pump_force_hiz = 1'b1;
			TCRB_DIAG_DET_RMS: detector_out = detector_rms;
			TCRB_DIAG_FB_DIV: test_pin_out = fb_div_clk;
			TCRB_DIAG_REF_DIV: test_pin_out = ref_div_clk;
			TCRB_DIAG_LO: test_pin_out = lo_clk;
			default: test_pin_out = 1'b0;
		endcase
	end
endmodule : tcrb_test_decode
`default_nettype wire

// *** tcrb_top.sv ***
// How it works
// - eight 8-bit write-only configuration registers at addresses 0x00 to 0x07
// - two unaddressed read-only status bytes returned on serial reads
// - three-bit trim field in test bits 7:5 scales filter centre 0.75 to 1.32
// - test bit 4 picks factory trim when 1, manual trim when 0
// - manual trim field acts only while the source bit is cleared
// - test bit 3 disables quadrature mixers when set
// - diagnostic code 000 in test bits 2:0 means normal operation
// - codes 001, 010, 011 force pump source, sink, high impedance
// - code 100 routes detector RMS, 101 to 111 route dividers and LO to test pin
// - trim code 100 is the nominal 571 kHz centre, others scale from it
// - shutdown pin low resets the whole bank and serial interface
`timescale 1ns/1ns
`default_nettype none
module tcrb_top
	import tcrb_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h60 // arbitrary value
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic shutdown_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [1:0] pump_current,
	input wire logic power_flag,
	input wire logic autoselect_flag_a,
	input wire logic autoselect_flag_e,
	input wire logic [1:0] osc_sel,
	input wire logic [2:0] subband_sel,
	input wire logic [2:0] adc_val,
	input wire logic [2:0] factory_trim,
	input wire logic fb_div_clk,
	input wire logic ref_div_clk,
	input wire logic lo_clk,
	input wire logic detector_rms,
	output logic [7:0] loop_config,
	output logic [7:0] oscillator_config,
	output logic [7:0] operating_control,
	output logic [7:0] reference_divide_power,
	output logic [7:0] reference_divider,
	output logic [7:0] feedback_divider_high,
	output logic [7:0] feedback_divider_low,
	output logic [2:0] trim_code,
	output logic [7:0] trim_scale_pct,
	output logic [9:0] centre_khz,
	output logic mixer_disable,
	output logic pump_force_source,
	output logic pump_force_sink,
	output logic pump_force_hiz,
	output logic detector_out,
	output logic test_pin_out
);
	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic arst_n;
	logic rs1_q;
	logic rs2_q;
	logic rst_s_n;

	// shutdown pin clears everything, bus included, above any software mode
	assign arst_n = rst_n & shutdown_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end
	assign rst_s_n = rs2_q;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [17:0] pins_raw;
	logic [17:0] sy1_q;
	logic [17:0] sy2_q;
	logic scl_p_q;
	logic sda_p_q;
	logic [7:0] st1;
	logic [7:0] st2;
	logic [2:0] ftrim_q;

	assign pins_raw = {scl_i, sda_i, pump_current, power_flag, autoselect_flag_a,
		autoselect_flag_e, osc_sel, subband_sel, adc_val, factory_trim};

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			sy1_q <= 18'h30000;
			sy2_q <= 18'h30000;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			sy1_q <= pins_raw;
			sy2_q <= sy1_q;
			scl_p_q <= sy2_q[17];
			sda_p_q <= sy2_q[16];
		end
	end

	// status bytes, upper three bits of the first read as zero
	assign st1 = {3'h0, sy2_q[15:11]};
	assign st2 = sy2_q[10:3];
	assign ftrim_q = sy2_q[2:0];

	// ----------------------------------------
	// serial engine and register bank
	// ----------------------------------------
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] rx_byte;

	assign scl = sy2_q[17];
	assign sda = sy2_q[16];
	assign scl_rise = scl & ~scl_p_q;
	assign scl_fall = ~scl & scl_p_q;
	assign bus_start = scl & scl_p_q & sda_p_q & ~sda;
	assign bus_stop = scl & scl_p_q & ~sda_p_q & sda;

	tcrb_state_t st_q, st_d;
	tcrb_state_t after_q, after_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] ptr_q, ptr_d;
	logic [7:0] tx_q, tx_d;
	logic rsel_q, rsel_d;
	logic oe_q, oe_d;
	logic [7:0] bank_q [NUM_CFG];
	logic [7:0] bank_d [NUM_CFG];

	assign rx_byte = {sh_q[6:0], sda};

	always_comb begin
		st_d = st_q;
		after_d = after_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		tx_d = tx_q;
		rsel_d = rsel_q;
		oe_d = oe_q;
		for (int i = 0; i < NUM_CFG; i++) begin
			bank_d[i] = bank_q[i];
		end
		if (bus_stop) begin
			st_d = TCRB_IDLE;
			oe_d = 1'b0;
		end else if (bus_start) begin
			st_d = TCRB_ADDR;
			cnt_d = 3'h0;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				TCRB_IDLE: oe_d = 1'b0;
				TCRB_ADDR, TCRB_REG, TCRB_WDATA: begin
					if (scl_rise) begin
						sh_d = rx_byte;
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == 3'h7) begin
							st_d = TCRB_ACK;
							case (st_q)
								TCRB_ADDR: begin
									if (rx_byte[7:1] != DEV_ADDR) begin
										st_d = TCRB_IDLE;
									end
									after_d = rx_byte[0] ? TCRB_RDATA : TCRB_REG;
									rsel_d = 1'b0;
								end
								TCRB_REG: begin
									ptr_d = rx_byte;
									after_d = TCRB_WDATA;
								end
								default: begin
									// out-of-map writes are acked and dropped
									if (ptr_q < 8'(NUM_CFG)) begin
										bank_d[ptr_q[2:0]] = rx_byte;
									end
									if (ptr_q == ADDR_FB_DIV_LOW) begin
										bank_d[ptr_q[2:0]] = rx_byte & FB_LOW_KEEP_MASK;
									end
									ptr_d = ptr_q + 8'h01;
									after_d = TCRB_WDATA;
								end
							endcase
						end
					end
				end
				TCRB_ACK: begin
					if (scl_fall) begin
						if (!oe_q) begin
							oe_d = 1'b1;
						end else begin
							st_d = after_q;
							cnt_d = 3'h0;
							oe_d = 1'b0;
							if (after_q == TCRB_RDATA) begin
								tx_d = st1;
								rsel_d = 1'b1;
								oe_d = ~st1[7];
							end
						end
					end
				end
				TCRB_RDATA: begin
					if (scl_fall) begin
						if (cnt_q == 3'h7) begin
							oe_d = 1'b0;
							st_d = TCRB_RACK;
						end else begin
							cnt_d = cnt_q + 3'h1;
							tx_d = {tx_q[6:0], 1'b0};
							oe_d = ~tx_q[6];
						end
					end
				end
				TCRB_RACK: begin
					if (scl_rise) begin
						st_d = sda ? TCRB_IDLE : TCRB_RNEXT;
					end
				end
				TCRB_RNEXT: begin
					if (scl_fall) begin
						// reads alternate between the two status bytes
						tx_d = rsel_q ? st2 : st1;
						rsel_d = ~rsel_q;
						oe_d = rsel_q ? ~st2[7] : ~st1[7];
						cnt_d = 3'h0;
						st_d = TCRB_RDATA;
					end
				end
				default: st_d = TCRB_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			st_q <= TCRB_IDLE;
			after_q <= TCRB_IDLE;
			cnt_q <= 3'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			tx_q <= 8'h00;
			rsel_q <= 1'b0;
			oe_q <= 1'b0;
			bank_q[0] <= RST_TEST_DIAG;
			bank_q[1] <= RST_LOOP_CONFIG;
			bank_q[2] <= RST_OSC_CONFIG;
			for (int i = 3; i < NUM_CFG; i++) begin
				bank_q[i] <= RST_OTHER;
			end
		end else begin
			st_q <= st_d;
			after_q <= after_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			tx_q <= tx_d;
			rsel_q <= rsel_d;
			oe_q <= oe_d;
			for (int i = 0; i < NUM_CFG; i++) begin
				bank_q[i] <= bank_d[i];
			end
		end
	end

	// open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe = oe_q;

	assign loop_config = bank_q[ADDR_LOOP_CONFIG[2:0]];
	assign oscillator_config = bank_q[ADDR_OSC_CONFIG[2:0]];
	assign operating_control = bank_q[ADDR_OPER_CONTROL[2:0]];
	assign reference_divide_power = bank_q[ADDR_REF_DIV_POWER[2:0]];
	assign reference_divider = bank_q[ADDR_REF_DIVIDER[2:0]];
	assign feedback_divider_high = bank_q[ADDR_FB_DIV_HIGH[2:0]];
	assign feedback_divider_low = bank_q[ADDR_FB_DIV_LOW[2:0]];

	// ----------------------------------------
	// test register decode
	// ----------------------------------------
	tcrb_test_decode u_test_decode (
		.test_reg(bank_q[ADDR_TEST_DIAG[2:0]]),
		.factory_trim(ftrim_q),
		.fb_div_clk(fb_div_clk),
		.ref_div_clk(ref_div_clk),
		.lo_clk(lo_clk),
		.detector_rms(detector_rms),
		.trim_code(trim_code),
		.trim_scale_pct(trim_scale_pct),
		.centre_khz(centre_khz),
		.mixer_disable(mixer_disable),
		.pump_force_source(pump_force_source),
		.pump_force_sink(pump_force_sink),
		.pump_force_hiz(pump_force_hiz),
		.detector_out(detector_out),
		.test_pin_out(test_pin_out)
	);
endmodule : tcrb_top
`default_nettype wire

// *** tuner_control_register_bank_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tuner_control_register_bank_tb;
	import tcrb_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic shutdown_n = 1'b1;
	logic scl_i, h_oe, sda_oe, sda_o;
	logic [12:0] st = 13'h1553;
	logic [3:0] src = 4'h0;
	logic [2:0] factory_trim = 3'h2;
	logic [2:0] trim_code;
	logic [5:0] dg;
	logic [7:0] scale;
	logic [9:0] khz;
	// expected scale in percent and centre in kHz per trim code, 571 kHz nominal
	logic [7:0] pct_exp [8] = '{8'h4b, 8'h50, 8'h56, 8'h5c, 8'h64, 8'h6c, 8'h77, 8'h84};
	logic [9:0] khz_exp [8] = '{10'h1ac, 10'h1c9, 10'h1eb, 10'h20d, 10'h23b, 10'h269,
		10'h2a7, 10'h2f2};
	logic [7:0] cfg [1:7];
	int num_errors = 0;
	int n_tests = 0;
	wire logic sda;
	// open drain with pull-up: low only while some side pulls
	assign sda = ~(h_oe | (sda_oe & ~sda_o));
	always #10 clk = ~clk;
	tcrb_top u_tcrb_top (.clk, .rst_n, .shutdown_n, .scl_i, .sda_i(sda), .sda_o, .sda_oe,
		.pump_current(st[12:11]), .power_flag(st[10]), .autoselect_flag_a(st[9]),
		.autoselect_flag_e(st[8]), .osc_sel(st[7:6]), .subband_sel(st[5:3]), .adc_val(st[2:0]),
		.factory_trim, .fb_div_clk(src[3]), .ref_div_clk(src[2]), .lo_clk(src[1]),
		.detector_rms(src[0]), .loop_config(cfg[1]), .oscillator_config(cfg[2]),
		.operating_control(cfg[3]), .reference_divide_power(cfg[4]), .reference_divider(cfg[5]),
		.feedback_divider_high(cfg[6]), .feedback_divider_low(cfg[7]), .trim_code,
		.trim_scale_pct(scale), .centre_khz(khz), .mixer_disable(dg[5]),
		.pump_force_source(dg[4]), .pump_force_sink(dg[3]), .pump_force_hiz(dg[2]),
		.detector_out(dg[1]), .test_pin_out(dg[0]));
	tcrb_host u_tcrb_host (.clk, .sda, .scl(scl_i), .sda_oe(h_oe));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_khz(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t centre %h expected %h", $time, got, exp);
		end
	endtask : chk_khz
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		logic [7:0] q[$];
		logic [7:0] r;
		logic k;
		q = {8'hc0, a, d};
		u_tcrb_host.start();
		foreach (q[i]) begin
			u_tcrb_host.xbyte(q[i], 1'b1, r, k);
			chk({7'h0, k}, 8'h00);
		end
		u_tcrb_host.stop();
	endtask : wr
	task automatic rd(input logic [7:0] e1, input logic [7:0] e2);
		logic [7:0] r;
		logic k;
		u_tcrb_host.start();
		u_tcrb_host.xbyte(8'hc1, 1'b1, r, k);
		chk({7'h0, k}, 8'h00);
		u_tcrb_host.xbyte(8'hff, 1'b0, r, k);
		chk(r, e1);
		u_tcrb_host.xbyte(8'hff, 1'b0, r, k);
		chk(r, e2);
		// third byte wraps back to the first status byte
		u_tcrb_host.xbyte(8'hff, 1'b1, r, k);
		chk(r, e1);
		u_tcrb_host.stop();
	endtask : rd
	task automatic test_done();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	initial begin
		#1800000;
		num_errors++;
		test_done();
	end
	initial begin
		logic [7:0] r;
		logic k;
		u_tcrb_host.ph(2);
		rst_n = 1'b1;
		u_tcrb_host.ph(5000);
		chk(cfg[1], RST_LOOP_CONFIG);
		chk(cfg[2], RST_OSC_CONFIG);
		chk({5'h0, trim_code}, 8'h02);
		wr(8'h00, '{8'h6b, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'hff});
		for (int i = 1; i < 8; i++) begin
			chk(cfg[i], i == 7 ? 8'hf8 : 8'(i * 17));
		end
		chk({2'h0, dg}, 8'h24);
		chk({5'h0, trim_code}, 8'h03);
		wr(8'h08, '{8'h99});
		chk(cfg[1], 8'h11);
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, '{8'(i * 32)});
			chk({5'h0, trim_code}, 8'(i));
			chk(scale, pct_exp[i]);
			chk_khz(khz, khz_exp[i]);
		end
		factory_trim = 3'h5;
		wr(8'h00, '{8'hf0});
		chk({5'h0, trim_code}, 8'h05);
		chk(scale, pct_exp[5]);
		chk_khz(khz, khz_exp[5]);
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, '{{4'h8, i[0], 3'(i)}});
			for (int p = 5; p <= 10; p += 5) begin
				src = 4'(p);
				u_tcrb_host.ph(1);
				chk({2'h0, dg}, {2'h0, i[0], i == 1, i == 2, i == 3, i == 4 && src[0],
					i == 5 ? src[3] : i == 6 ? src[2] : i == 7 && src[1]});
			end
		end
		rd(8'h15, 8'h53);
		st = 13'h0aac;
		rd(8'h0a, 8'hac);
		u_tcrb_host.start();
		u_tcrb_host.xbyte(8'hc2, 1'b1, r, k);
		chk({7'h0, k}, 8'h01);
		u_tcrb_host.stop();
		wr(8'h01, '{8'h5a});
		chk(cfg[1], 8'h5a);
		u_tcrb_host.start();
		u_tcrb_host.xbyte(8'hc0, 1'b1, r, k);
		chk({7'h0, k}, 8'h00);
		shutdown_n = 1'b0;
		u_tcrb_host.ph(3);
		shutdown_n = 1'b1;
		u_tcrb_host.stop();
		chk(cfg[1], RST_LOOP_CONFIG);
		chk(cfg[7], 8'h00);
		test_done();
	end
endmodule : tuner_control_register_bank_tb
`default_nettype wire
